/* File: hw/stream_packet_endpoint.sv */
// Purpose: stream slave and master endpoint with packet framing and events
// Assumes: inputs synchronous to clk_in, upstream keeps its side of the stream
// Notes: one register stage from slave to master, events are level wires
//
// How it works
// - counting mode takes exactly the set beat count
// - pass mode delays tlast like the data
// - sum accumulates, checked on tlast beat
// - never send an all-null trailing beat
// - null keep bits only on last beat
// - keep looked at only on the closing beat
// - keep unused without packets is fine
// - user bits only supplement the data
// - events follow condition, never sticky
// - events are valid-only wires, no handshake
// - events never stall the data path
// - four 16-bit complex elements per beat
// - missing last event at expected end
// - unexpected last event elsewhere
// - padding bits sign-extended for signed data
`timescale 1ns/10ps
`default_nettype none
module stream_packet_endpoint
    import stream_endpoint_pkg::*;
#(
    parameter logic [CNT_W-1:0] PKT_LEN = PKT_LEN_DEF
)
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire stream_endpoint_pkg::pkt_mode_t mode_in,
    input wire stream_endpoint_pkg::beat_t s_beat_in,
    output logic s_ready_out,
    input wire logic m_ready_in,
    output stream_endpoint_pkg::beat_t m_beat_out,
    output stream_endpoint_pkg::events_t events_out,
    output logic [stream_endpoint_pkg::KEEP_W-1:0] last_keep_out
);
    import stream_endpoint_pkg::*;

    state_t st_q;   // registered state except slave ready
    state_t st_d;   // next state
    logic rdy_q;    // registered slave ready
    logic take;     // beat accepted this cycle
    logic pipe_free;

    // sign-extend each 12-bit sample into its 16-bit lane
    function automatic logic [DATA_W-1:0] sext_lanes(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = d;
        for (int i = 0; i < 2 * ELEM_N; i++)
        begin
            r[i*LANE_W +: LANE_W] = {{(LANE_W-SAMP_W){d[i*LANE_W+SAMP_W-1]}},
                                    d[i*LANE_W +: SAMP_W]};
        end
        return r;
    endfunction

    // keep on a beat: full unless it closes a packet
    // non-closing beats never look at keep, so a source without keep works
    // an all-null closing keep would be an empty trailing beat, so it is
    // widened to full rather than forwarded downstream
    function automatic logic [KEEP_W-1:0] keep_of(input beat_t b, input logic ends);
        logic [KEEP_W-1:0] k;
        k = KEEP_ALL;
        if (ends && b.keep != KEEP_NONE)
        begin
            k = b.keep;
        end
        return k;
    endfunction

    // output stage empties or moves on; ready is registered, so we only
    // accept when the stage is free next cycle regardless of event state
    assign pipe_free = !st_q.out.valid || m_ready_in;
    assign take = s_beat_in.valid && rdy_q;

    // next-state logic for framing, checksum and events
    always_comb
    begin
        logic ends;
        logic at_end;
        logic [DATA_W-1:0] sum_n;
        ends = 1'b0;
        at_end = (st_q.beat_cnt == PKT_LEN - CNT_ONE);
        sum_n = st_q.sum;
        st_d = st_q;
        // output handshake completes
        if (m_ready_in)
        begin
            st_d.out.valid = 1'b0;
        end
        // events are cleared unless re-raised by this beat
        st_d.ev = '0;
        if (take)
        begin
            sum_n = st_q.sum ^ s_beat_in.data;
            case (mode_in)
                MODE_PASS:
                begin
                    ends = s_beat_in.last;
                end
                MODE_LAST:
                begin
                    ends = s_beat_in.last;
                    if (s_beat_in.last)
                    begin
                        // end-of-packet check: folded sum must be zero
                        st_d.ev.sum_bad = (sum_n != SUM_ZERO);
                        sum_n = SUM_ZERO;
                    end
                end
                MODE_COUNT:
                begin
                    ends = at_end;
                    st_d.ev.missing_last = at_end && !s_beat_in.last;
                    st_d.ev.unexpected_last = !at_end && s_beat_in.last;
                    // wrap counter after the final beat
                    st_d.beat_cnt = at_end ? CNT_ZERO : st_q.beat_cnt + CNT_ONE;
                end
                default:
                begin
                    ends = s_beat_in.last;
                end
            endcase
            st_d.sum = sum_n;
            st_d.out.valid = 1'b1;
            st_d.out.data = sext_lanes(s_beat_in.data);
            st_d.out.user = s_beat_in.user; // data stays meaningful alone
            st_d.out.last = ends;
            // keep only sampled on closing beat; null beat never emitted
            st_d.out.keep = keep_of(s_beat_in, ends);
            if (ends)
            begin
                st_d.last_keep = st_d.out.keep;
            end
        end
        if (mode_in != MODE_COUNT)
        begin
            st_d.beat_cnt = CNT_ZERO;
        end
        // checksum only lives in tlast mode; a mode switch must not carry
        // a stale partial sum into the first checked packet
        if (mode_in != MODE_LAST)
        begin
            st_d.sum = SUM_ZERO;
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_q <= '0;
            rdy_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            // ready depends only on output space, never on events
            // ready is registered, so it may only promise a free stage for
            // the next edge; trades half rate even without stall for a short path
            rdy_q <= !st_d.out.valid || (!take && pipe_free);
        end
    end

    assign s_ready_out = rdy_q;
    assign m_beat_out = st_q.out;
    assign events_out = st_q.ev; // valid-only wires
    assign last_keep_out = st_q.last_keep;

    // assertions
    chk_keep_only_last: assert property (@(posedge clk_in) disable iff (!nrst_in)
        m_beat_out.valid && !m_beat_out.last |-> m_beat_out.keep == KEEP_ALL)
        else $error("null bytes on a non-final beat");
    chk_no_null_beat: assert property (@(posedge clk_in) disable iff (!nrst_in)
        m_beat_out.valid |-> m_beat_out.keep != KEEP_NONE)
        else $error("all-null beat emitted");
    chk_last_follows: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take && mode_in == MODE_PASS |=> m_beat_out.last == $past(s_beat_in.last))
        else $error("tlast latency differs from data");
    chk_missing_last: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take && mode_in == MODE_COUNT && st_q.beat_cnt == PKT_LEN - CNT_ONE
        && !s_beat_in.last |=> events_out.missing_last)
        else $error("missing last not flagged");
    chk_unexp_last: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take && mode_in == MODE_COUNT && st_q.beat_cnt != PKT_LEN - CNT_ONE
        && s_beat_in.last |=> events_out.unexpected_last)
        else $error("unexpected last not flagged");
    chk_count_end: assert property (@(posedge clk_in) disable iff (!nrst_in)
        take && mode_in == MODE_COUNT && st_q.beat_cnt == PKT_LEN - CNT_ONE
        |=> m_beat_out.last && st_q.beat_cnt == CNT_ZERO)
        else $error("count framing wrong");
    chk_event_drops: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !take |=> events_out == '0)
        else $error("event held without cause");
    chk_no_stall: assert property (@(posedge clk_in) disable iff (!nrst_in)
        events_out != '0 && !m_beat_out.valid |-> s_ready_out)
        else $error("stalled on event");
    chk_sign_ext: assert property (@(posedge clk_in) disable iff (!nrst_in)
        m_beat_out.valid |-> m_beat_out.data[LANE_W-1] == m_beat_out.data[SAMP_W-1])
        else $error("padding not sign-extended");
    chk_sum_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
        mode_in != MODE_LAST |=> st_q.sum == SUM_ZERO)
        else $error("stale checksum outside tlast mode");
    cov_unexp: cover property (@(posedge clk_in) disable iff (!nrst_in)
        events_out.unexpected_last);
    cov_count_pkt: cover property (@(posedge clk_in) disable iff (!nrst_in)
        mode_in == MODE_COUNT && m_beat_out.valid && m_beat_out.last);
    cov_missing: cover property (@(posedge clk_in) disable iff (!nrst_in)
        events_out.missing_last);
    cov_sum_bad: cover property (@(posedge clk_in) disable iff (!nrst_in) events_out.sum_bad);
    cov_remainder: cover property (@(posedge clk_in) disable iff (!nrst_in)
        m_beat_out.valid && m_beat_out.keep != KEEP_ALL);
endmodule // stream_packet_endpoint
`default_nettype wire

/* File: hw/stream_endpoint_pkg.sv */
// Purpose: shared constants and carrier types for the stream packet endpoint
// Assumes: one clock, active-low asynchronous reset
// Notes: a beat is one 128-bit word carrying four complex elements
package stream_endpoint_pkg;
    // data word geometry: four complex elements, 16-bit lanes
    localparam int unsigned DATA_W = 128;
    localparam int unsigned KEEP_W = DATA_W / 8;
    localparam int unsigned USER_W = 8;
    localparam int unsigned ELEM_N = 4;
    localparam int unsigned LANE_W = 16;
    localparam int unsigned SAMP_W = 12;
    localparam int unsigned CNT_W = 16;
    // default packet length in beats
    localparam logic [CNT_W-1:0] PKT_LEN_DEF = 16'h0008;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] SUM_ZERO = 128'h0;
    localparam logic [KEEP_W-1:0] KEEP_ALL = 16'hffff;
    localparam logic [KEEP_W-1:0] KEEP_NONE = 16'h0000;

    // packet boundary handling of the slave side
    typedef enum logic [1:0] {
        MODE_PASS = 2'b00,   // no boundaries, tlast passed through
        MODE_LAST = 2'b01,   // tlast ends packets, checksum checked
        MODE_COUNT = 2'b10   // fixed beat count, tlast only raises events
    } pkt_mode_t;

    // one stream beat
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
        logic [KEEP_W-1:0] keep;
        logic [USER_W-1:0] user;
        logic last;
    } beat_t;

    // event wires, level only
    typedef struct packed {
        logic missing_last;
        logic unexpected_last;
        logic sum_bad;
    } events_t;

    // registered state of the endpoint except slave ready
    typedef struct packed {
        beat_t out;
        logic [CNT_W-1:0] beat_cnt;
        logic [DATA_W-1:0] sum;
        logic [KEEP_W-1:0] last_keep;
        events_t ev;
    } state_t;
endpackage

/* File: test/stream_sink_model.sv */
// Purpose: downstream stream sink for the endpoint bench
// Assumes: ready may be dropped at any edge by a stream slave
// Notes: slow mode stalls every other cycle to exercise hold
`timescale 1ns/10ps
`default_nettype none
module stream_sink_model
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic slow_in,
    output var logic ready_out = 1'b0
);
    logic ph_q = 1'b0; // stall phase
    // events are left unconnected here on purpose
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ready_out <= 1'b0;
        end
        else
        begin
            ph_q <= ~ph_q;
            ready_out <= slow_in ? ph_q : 1'b1;
        end
    end
endmodule // stream_sink_model
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the stream packet endpoint
// Assumes: short packet length parameter of three beats
// Notes: outputs are sampled on the falling edge, where they are settled
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    import stream_endpoint_pkg::*;
    localparam logic [CNT_W-1:0] LEN = 16'h0003; // beats per packet
    localparam logic [DATA_W-1:0] D0 = {8{16'hf801}}; // sign-extended lanes
    localparam logic [DATA_W-1:0] D1 = {4{16'h07ff, 16'h0123}};
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic slow = 1'b0;
    logic m_ready_in;
    logic s_ready_out;
    pkt_mode_t mode_in = MODE_PASS;
    beat_t s_beat_in = '0;
    beat_t m_beat_out;
    events_t events_out;
    logic [KEEP_W-1:0] last_keep_out;
    beat_t got[$]; // beats taken downstream
    int n_mismatch = 0;
    int checked = 0;
    int n_miss = 0;
    int n_unexp = 0;
    int n_bad = 0;

    stream_packet_endpoint #(.PKT_LEN(LEN)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .mode_in(mode_in), .s_beat_in(s_beat_in), .s_ready_out(s_ready_out),
        .m_ready_in(m_ready_in), .m_beat_out(m_beat_out), .events_out(events_out),
        .last_keep_out(last_keep_out));
    stream_sink_model i_sink (.clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow),
        .ready_out(m_ready_in));

    initial forever #5 clk_in = ~clk_in;

    // monitor: a beat is taken at the next rise if valid and ready now
    always @(negedge clk_in)
    begin
        if (m_beat_out.valid && m_ready_in) got.push_back(m_beat_out);
        if (events_out.missing_last) n_miss++;
        if (events_out.unexpected_last) n_unexp++;
        if (events_out.sum_bad) n_bad++;
    end

    task automatic final_report();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hold the beat until the rise at which ready was high
    // upstream keep is sent as given; scen_pass sends null keep bits on a non-closing beat
    task automatic send(input logic [DATA_W-1:0] d, input logic [KEEP_W-1:0] k,
        input logic l);
        logic rdy;
        s_beat_in <= '{valid: 1'b1, data: d, keep: k, user: 8'h5a, last: l};
        rdy = 1'b0;
        while (!rdy)
        begin
            @(negedge clk_in);
            rdy = s_ready_out;
            @(posedge clk_in);
        end
    endtask

    // drop valid, then wait bounded for n beats downstream
    task automatic finish_pkt(input int n);
        int i;
        s_beat_in.valid <= 1'b0;
        for (i = 0; i < 100 && got.size() < n; i++) @(posedge clk_in);
        `CHK(got.size(), n)
    endtask

    task automatic start(input pkt_mode_t m, input logic s);
        got.delete();
        n_miss = 0; n_unexp = 0; n_bad = 0;
        mode_in <= m;
        slow <= s;
        @(posedge clk_in);
    endtask

    task automatic scen_pass();
        start(MODE_PASS, 1'b1);
        send(D0, 16'h00ff, 1'b0);
        send(D1, 16'h00ff, 1'b1);
        finish_pkt(2);
        `CHK(got[0].data, D0)
        `CHK(got[0].last, 1'b0)
        `CHK(got[0].keep, KEEP_ALL)
        `CHK(got[1].last, 1'b1)
        `CHK(got[1].keep, 16'h00ff)
        `CHK(last_keep_out, 16'h00ff)
    endtask

    task automatic scen_sum();
        start(MODE_LAST, 1'b0);
        send(D0, KEEP_ALL, 1'b0);
        send(D0, KEEP_ALL, 1'b1);
        send(D0, KEEP_ALL, 1'b0);
        send(D1, KEEP_ALL, 1'b1);
        finish_pkt(4);
        `CHK(n_bad, 1)
        `CHK(got[3].data, D1)
        `CHK(got[3].user, 8'h5a)
    endtask

    task automatic scen_count();
        start(MODE_COUNT, 1'b1);
        send(D0, KEEP_ALL, 1'b0);
        send(D1, KEEP_ALL, 1'b1);
        send(D0, KEEP_ALL, 1'b0);
        send(D1, KEEP_ALL, 1'b0);
        send(D0, KEEP_ALL, 1'b0);
        send(D1, KEEP_ALL, 1'b1);
        finish_pkt(6);
        `CHK(got[1].last, 1'b0)
        `CHK(got[2].last, 1'b1)
        `CHK(got[5].last, 1'b1)
        `CHK(n_unexp, 1)
        `CHK(n_miss, 1)
    endtask

    // an all-null closing beat must leave with full keep
    task automatic scen_null();
        start(MODE_LAST, 1'b0);
        send(D1, KEEP_NONE, 1'b1);
        finish_pkt(1);
        `CHK(got[0].keep, KEEP_ALL)
        `CHK(got[0].last, 1'b1)
    endtask

    initial
    begin
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        scen_pass();
        scen_sum();
        scen_count();
        scen_null();
        final_report();
    end

    // watchdog: all scenarios need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
